// ### rtl/sssout_defs.vh
// constants for the sampling strobe output block
`ifndef SSSOUT_DEFS_VH
`define SSSOUT_DEFS_VH
// register addresses (16-bit memory space)
`define SSS_ADDR_CTRL 16'hff76
`define SSS_ADDR_LEVEL 16'hff77
`define SSS_ADDR_STATUS 16'hff78
// control register bit positions
`define SSS_CTL_CLR 0
`define SSS_CTL_SET 1
`define SSS_CTL_OE 2
`define SSS_CTL_SRC 3
`define SSS_CTL_MODE 4
`define SSS_CTL_PRE 5
`define SSS_CTL_CNTB 6
`define SSS_CTL_CNTA 7
// reset values
`define SSS_CTRL_RESET 8'h00
`define SSS_LEVEL_RESET 5'h00
`define SSS_STATUS_RESET 5'h00
// number of sampled pins
`define SSS_PINS 5
// subsystem clock period in ns (32.768 kHz) and the core clock period
`define SSS_SUB_PERIOD_NS 30518
`define SSS_CLK_PERIOD_NS 100
// one subsystem cycle in core clocks, rounded down, never below one
`define SSS_SUB_CYCLES ((`SSS_SUB_PERIOD_NS / `SSS_CLK_PERIOD_NS) < 1 ? 1 : \
  (`SSS_SUB_PERIOD_NS / `SSS_CLK_PERIOD_NS))
`endif

// ### rtl/sssout_sampler.v
// per-pin latch and active level compare for the sensor inputs
`include "sssout_defs.vh"
module sssout_sampler (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire enable,
  input wire sample,
  input wire [4:0] level,
  input wire [4:0] pins,
  // results
  output wire [4:0] status,
  output wire [4:0] irq
);
  genvar i;
  generate
    for (i = 0; i < `SSS_PINS; i = i + 1)
    begin : g_pin
      reg bit_q;
      reg irq_q;
      // latch on the strobe falling edge, only in sampling mode
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          bit_q <= 1'b0;
          irq_q <= 1'b0;
        end
        else
        begin
          irq_q <= 1'b0;
          if (enable && sample)
          begin
            bit_q <= pins[i];
            irq_q <= (pins[i] == level[i]);
          end
        end
      end
      assign status[i] = bit_q;
      assign irq[i] = irq_q;
    end
  endgenerate
endmodule

// ### rtl/sssout_top.v
// sampling strobe output controller with sensor pin sampler
//
// Behaviour
// - status register and pin interrupts work only in sampling mode
// - sampling mode: clearing output enable holds the pin level
// - sampling mode re-enable after high hold: pin falls on next subclock falling edge
// - sample five pins on each falling edge of the strobe
// - re-enable while held low: interrupts from the pins sampled one clock after the write
// - timer mode: disable freezes level, re-enable drives it again
// - after a status read the pins are re-sampled one subclock later
// - after counter A read the count is refetched one source clock later
// - active level 0 fires on low, 1 fires on high
// - active level register: 5 bits, upper bits read zero, reset zero
// - status register latches on strobe fall, read-only, resets zero
// - source select sets strobe rate or timer pulse width
// - mode select 0 is timer mode, 1 is sampling mode
// - source select 0 picks prescaler, 1 picks counter A match
// - init pair 00 keeps, 01 clears, 10 sets; 11 prohibited
`include "sssout_defs.vh"
module sssout_top (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // register port
  input wire [15:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  // timing sources from the counters and the subsystem clock
  input wire SUB_FALL,
  input wire PRESCALE_TICK,
  input wire MATCH_TICK,
  input wire CNTA_SRC_TICK,
  // strobe pin
  output wire STROBE_OUT,
  output wire STROBE_OE,
  // sensor pins
  input wire [4:0] SENSOR_IN,
  // events
  output wire [4:0] PIN_IRQ,
  output wire CNTA_REFETCH
);
  // ****************************************
  // reset release
  // ****************************************
  reg rst_s1;
  reg rst_s2;
  wire rst_n;
  // two flops so the release is clean against CLK
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] ctrl;
  reg [4:0] level;
  wire [4:0] status;
  wire wr_ctrl = WR && (ADDR == `SSS_ADDR_CTRL);
  wire wr_level = WR && (ADDR == `SSS_ADDR_LEVEL);
  wire rd_status = RD && (ADDR == `SSS_ADDR_STATUS);
  wire mode = ctrl[`SSS_CTL_MODE];
  wire oe = ctrl[`SSS_CTL_OE];
  wire [7:0] next_ctrl;
  // mode, source and init bits (4, 3, 1, 0) ignore writes while the output is enabled
  assign next_ctrl[7:5] = WDATA[7:5];
  assign next_ctrl[`SSS_CTL_OE] = WDATA[`SSS_CTL_OE];
  assign next_ctrl[4:3] = oe ? ctrl[4:3] : WDATA[4:3];
  assign next_ctrl[1:0] = oe ? 2'b00 : WDATA[1:0];

  // control and active level storage
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `SSS_CTRL_RESET;
      level <= `SSS_LEVEL_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= next_ctrl;
      if (wr_level)
        level <= WDATA[4:0];
    end
  end

  // read mux, unused bits read zero
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      RDATA <= 8'h00;
    else if (ADDR == `SSS_ADDR_CTRL)
      RDATA <= {ctrl[7:2], 2'b00};
    else if (ADDR == `SSS_ADDR_LEVEL)
      RDATA <= {3'b000, level};
    else if (ADDR == `SSS_ADDR_STATUS)
      RDATA <= {3'b000, status};
    else
      RDATA <= 8'h00;
  end

  // ****************************************
  // output flip-flop and strobe
  // ****************************************
  reg out_ff;
  reg oe_q;
  reg restart;
  reg strobe_fall;
  wire src_tick = ctrl[`SSS_CTL_SRC] ? MATCH_TICK : PRESCALE_TICK;
  wire oe_rise = oe && !oe_q;
  // toggles on the chosen source while enabled; init writes set or clear it only while disabled
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_ff <= 1'b0;
      oe_q <= 1'b0;
      restart <= 1'b0;
      strobe_fall <= 1'b0;
    end
    else
    begin
      oe_q <= oe;
      strobe_fall <= 1'b0;
      if (wr_ctrl && !oe && WDATA[1:0] == 2'b01)
        out_ff <= 1'b0;
      else if (wr_ctrl && !oe && WDATA[1:0] == 2'b10)
        out_ff <= 1'b1;
      else if (mode && oe_rise && out_ff)
        restart <= 1'b1;
      else if (restart)
      begin
        if (SUB_FALL)
        begin
          out_ff <= 1'b0;
          restart <= 1'b0;
          strobe_fall <= 1'b1;
        end
      end
      else if (oe && src_tick)
      begin
        out_ff <= !out_ff;
        strobe_fall <= out_ff;
      end
    end
  end
  // timer mode releases the pin when disabled; sampling mode keeps driving it
  assign STROBE_OUT = out_ff;
  assign STROBE_OE = oe || mode;

  // ****************************************
  // status refresh after read
  // ****************************************
  reg refresh;
  reg [11:0] sub_cnt;
  reg refresh_fire;
  // one subsystem clock after a read, take the pins again
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refresh <= 1'b0;
      sub_cnt <= 12'h000;
      refresh_fire <= 1'b0;
    end
    else
    begin
      refresh_fire <= 1'b0;
      if (rd_status)
      begin
        refresh <= 1'b1;
        sub_cnt <= 12'h000;
      end
      else if (refresh)
      begin
        if (sub_cnt == `SSS_SUB_CYCLES - 1)
        begin
          refresh <= 1'b0;
          refresh_fire <= 1'b1;
        end
        else
          sub_cnt <= sub_cnt + 12'h001;
      end
    end
  end

  // ****************************************
  // counter A refetch after read
  // ****************************************
  reg cnta_wait;
  reg cnta_fire;
  wire rd_cnta = RD && (ADDR == `SSS_ADDR_CTRL) && ctrl[`SSS_CTL_CNTA];
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnta_wait <= 1'b0;
      cnta_fire <= 1'b0;
    end
    else
    begin
      cnta_fire <= 1'b0;
      if (rd_cnta)
        cnta_wait <= 1'b1;
      else if (cnta_wait && CNTA_SRC_TICK)
      begin
        cnta_wait <= 1'b0;
        cnta_fire <= 1'b1;
      end
    end
  end
  assign CNTA_REFETCH = cnta_fire;

  // ****************************************
  // sampler
  // ****************************************
  // enabling while held low raises interrupts from the present pins
  wire sample_now = strobe_fall || refresh_fire || (mode && oe_rise && !out_ff);
  sssout_sampler u_sampler (
    .clk(CLK),
    .rst_n(rst_n),
    .enable(mode),
    .sample(sample_now),
    .level(level),
    .pins(SENSOR_IN),
    .status(status),
    .irq(PIN_IRQ)
  );
endmodule

// ### sim/sssout_chk.sv
// assertions on the ports of the strobe block
module sssout_chk (
  // watched ports
  input logic CLK,
  input logic RST_N,
  input logic [15:0] ADDR,
  input logic WR,
  input logic [7:0] WDATA,
  input logic [7:0] RDATA,
  input logic SUB_FALL,
  input logic PRESCALE_TICK,
  input logic MATCH_TICK,
  input logic STROBE_OUT,
  input logic STROBE_OE,
  input logic [4:0] PIN_IRQ,
  input logic CNTA_REFETCH
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ****
  // shadow state
  // ****
  logic md;
  logic oe;
  wire cw = WR && ADDR == 16'hff76;
  wire ev = WR || SUB_FALL || PRESCALE_TICK || MATCH_TICK;
  // mode shadow is locked while enabled, like the real bits
  always @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      md <= 1'b0;
      oe <= 1'b0;
    end
    else if (cw)
    begin
      md <= oe ? md : WDATA[4];
      oe <= WDATA[2];
    end
  irq_timer_a: assert property (!md && !$past(md) |-> PIN_IRQ == 5'h00)
    else $error("pin irq in timer mode");
  irq_pulse_a: assert property (PIN_IRQ != 5'h00 |=> PIN_IRQ == 5'h00)
    else $error("pin irq too long");
  level_read_a: assert property (ADDR == 16'hff77 |=> RDATA[7:5] == 3'h0)
    else $error("level upper bits set");
  status_read_a: assert property (ADDR == 16'hff78 |=> RDATA[7:5] == 3'h0)
    else $error("status upper bits set");
  unmapped_zero_a: assert property (ADDR < 16'hff76 || ADDR > 16'hff78 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  refetch_pulse_a: assert property (CNTA_REFETCH |=> !CNTA_REFETCH)
    else $error("refetch too long");
  oe_drive_a: assert property (STROBE_OE == (oe || md))
    else $error("pin drive wrong");
  strobe_cause_a: assert property ($changed(STROBE_OUT) |-> $past(ev) || $past(ev, 2))
    else $error("strobe moved alone");
endmodule
bind sssout_top sssout_chk i_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .WDATA(WDATA), .RDATA(RDATA),
  .SUB_FALL(SUB_FALL), .PRESCALE_TICK(PRESCALE_TICK), .MATCH_TICK(MATCH_TICK), .STROBE_OUT(STROBE_OUT),
  .STROBE_OE(STROBE_OE), .PIN_IRQ(PIN_IRQ), .CNTA_REFETCH(CNTA_REFETCH));

// ### sim/sssout_sensor.sv
// sensor model driving the five sampled pins
module sssout_sensor (
  // clock and wanted levels
  input logic CLK,
  input logic [4:0] pat,
  // sensor pins
  output logic [4:0] SENSOR_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  // move off the rising edge so sampling never races the change
  always @(negedge CLK) SENSOR_IN <= pat;
endmodule

// ### sim/sssout_bench.sv
// testbench for the sampling strobe output block
module sssout_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and checks
  // ****
  logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
  logic SUB_FALL = 1'b0, PRESCALE_TICK = 1'b0, MATCH_TICK = 1'b0, CNTA_SRC_TICK = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  logic [4:0] pat = 5'h00;
  logic [5:0] got = 6'h00;
  wire [7:0] RDATA;
  wire [4:0] SENSOR_IN, PIN_IRQ;
  wire STROBE_OUT, STROBE_OE, CNTA_REFETCH;
  int bad_count = 0, checks_done = 0;
  always #50 CLK = ~CLK;
  // sticky capture, the event pulses last one cycle only
  always @(posedge CLK) got <= got | {CNTA_REFETCH, PIN_IRQ};
  sssout_top i_dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
    .SUB_FALL(SUB_FALL), .PRESCALE_TICK(PRESCALE_TICK), .MATCH_TICK(MATCH_TICK), .CNTA_SRC_TICK(CNTA_SRC_TICK),
    .STROBE_OUT(STROBE_OUT), .STROBE_OE(STROBE_OE), .SENSOR_IN(SENSOR_IN), .PIN_IRQ(PIN_IRQ),
    .CNTA_REFETCH(CNTA_REFETCH));
  sssout_sensor i_sen (.CLK(CLK), .pat(pat), .SENSOR_IN(SENSOR_IN));
  task final_report;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(negedge CLK);
    WR = 1'b0;
    @(negedge CLK);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    ADDR = a;
    RD = 1'b1;
    @(negedge CLK);
    RD = 1'b0;
    chk("rdata", RDATA, e);
    // idle cycle so a following read never re-raises the strobe at once
    @(negedge CLK);
  endtask
  // one tick: 0 prescaler, 1 match, 2 subclock fall, 3 counter A clock
  task pulse(input int w);
    {CNTA_SRC_TICK, SUB_FALL, MATCH_TICK, PRESCALE_TICK} = 4'h1 << w;
    @(negedge CLK);
    {CNTA_SRC_TICK, SUB_FALL, MATCH_TICK, PRESCALE_TICK} = 4'h0;
    repeat (3) @(negedge CLK);
  endtask
  task wirq(input logic [4:0] e);
    int i;
    for (i = 0; i < 20 && got[4:0] === 5'h00; i++) @(negedge CLK);
    if (i == 20)
    begin
      bad_count++;
      final_report;
    end
    else
    begin
      chk("irq", got[4:0], e);
      got = 6'h00;
    end
  endtask
  initial
  begin
    repeat (5) @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
    pat = 5'h0a;
    rd(16'hff77, 8'h00);
    rd(16'hff78, 8'h00);
    wr(16'hff77, 8'hef);
    rd(16'hff77, 8'h0f);
    wr(16'hff78, 8'hff);
    rd(16'hff78, 8'h00);
    rd(16'hff79, 8'h00);
    // mode first, then the prescaler, counter B and output enables together
    wr(16'hff76, 8'h10);
    got = 6'h00;
    wr(16'hff76, 8'h74);
    wirq(5'h1a);
    rd(16'hff78, 8'h0a);
    pat = 5'h15;
    repeat (320) @(negedge CLK);
    rd(16'hff78, 8'h15);
    pat = 5'h0a;
    // let the refresh caused by that read pass before counting events
    repeat (320) @(negedge CLK);
    got = 6'h00;
    pulse(0);
    chk("strobe", STROBE_OUT, 1'b1);
    pulse(1);
    chk("strobe", STROBE_OUT, 1'b1);
    pulse(0);
    wirq(5'h1a);
    pulse(0);
    // stop all enables in one write, the mode bits stay locked
    wr(16'hff76, 8'h10);
    pulse(0);
    chk("hold", STROBE_OUT, 1'b1);
    chk("hold drive", STROBE_OE, 1'b1);
    got = 6'h00;
    wr(16'hff76, 8'h74);
    pulse(2);
    chk("fall", STROBE_OUT, 1'b0);
    wirq(5'h1a);
    wr(16'hff76, 8'h10);
    wr(16'hff76, 8'h00);
    got = 6'h00;
    wr(16'hff76, 8'h02);
    chk("port", STROBE_OE, 1'b0);
    wr(16'hff76, 8'h64);
    chk("set", STROBE_OUT, 1'b1);
    // the high to low toggle would strobe the sampler if mode were ignored
    pulse(0);
    chk("toggle", STROBE_OUT, 1'b0);
    chk("timer irq", got, 8'h00);
    pulse(0);
    wr(16'hff76, 8'h00);
    pulse(0);
    wr(16'hff76, 8'h64);
    chk("frozen", STROBE_OUT, 1'b1);
    wr(16'hff76, 8'h00);
    wr(16'hff76, 8'h09);
    wr(16'hff76, 8'hcc);
    chk("clear", STROBE_OUT, 1'b0);
    pulse(1);
    chk("match", STROBE_OUT, 1'b1);
    pulse(0);
    chk("match only", STROBE_OUT, 1'b1);
    got = 6'h00;
    ADDR = 16'hff76;
    RD = 1'b1;
    @(negedge CLK);
    RD = 1'b0;
    pulse(3);
    chk("refetch", got[5], 1'b1);
    final_report;
  end
endmodule
